// ---- src/bus_arb_pkg.sv ----
// constants, types and states shared by the system bus arbitration logic
// How it works
// - mastership changes only when idle or at quad end
// - cache line fills are never split between masters
// - every system sdram access is eight half-word beats; a video access is four such bursts
// - pending video request beats system bus request
// - video traffic never stalls rom or peripheral access
// - fast peripheral bus runs on system clock
// - slow peripherals on crystal, registers at bus speed
// - all crystal domain signals are resynchronised safely
// - slow peripheral bus refuses dma transfers
// - dma channel select steers fast peripheral strobes
// - dma controller outranks processor core for grant
package bus_arb_pkg;

    localparam int unsigned ADDR_W       = 32;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned QUAD_LO      = 2;          // address bit 2
    localparam int unsigned QUAD_HI      = 3;          // address bit 3
    localparam logic [1:0]  QUAD_LAST    = 2'h3;       // last word of a quad
    localparam int unsigned REGION_LO    = 28;         // region field low bit
    localparam int unsigned REGION_HI    = 31;         // region field high bit
    localparam logic [3:0]  REGION_ROM   = 4'h0;
    localparam logic [3:0]  REGION_SDRAM = 4'h4;
    localparam logic [3:0]  REGION_FAST  = 4'h8;
    localparam logic [3:0]  REGION_SLOW  = 4'h9;

    // sdram burst of eight half-words is one quad-word of the 32-bit bus
    localparam int unsigned SDRAM_BEATS    = 8;
    localparam int unsigned BEAT_W         = 3;
    localparam logic [2:0]  BEAT_LAST      = 3'(SDRAM_BEATS - 1);
    // a sixteen word video burst is four quad-word sdram bursts
    localparam int unsigned VIDEO_WORDS    = 16;
    localparam int unsigned WORDS_PER_QUAD = 4;
    localparam logic [1:0]  VID_QUAD_LAST  = 2'(VIDEO_WORDS / WORDS_PER_QUAD - 1);
    localparam logic [ADDR_W-1:0] QUAD_BYTES = 32'h0000_0010;

    localparam int unsigned DMA_CHANNELS = 4;
    localparam int unsigned CHAN_W       = 2;
    localparam int unsigned SYNC_STAGES  = 3;

    // one transfer as seen on the system bus
    typedef struct packed {
        logic              active;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } asb_xfer_t;

    // dma controller side-band towards the fast bridge
    typedef struct packed {
        logic              ack;
        logic [CHAN_W-1:0] chan;
    } dma_side_t;

    typedef enum logic [1:0] {
        OWN_CPU = 2'b01,
        OWN_DMA = 2'b10
    } owner_t;

    typedef enum logic [2:0] {
        SD_IDLE = 3'b001,
        SD_SYS  = 3'b010,
        SD_VID  = 3'b100
    } sd_state_t;

    typedef enum logic [3:0] {
        RG_ROM   = 4'b0001,
        RG_SDRAM = 4'b0010,
        RG_FAST  = 4'b0100,
        RG_SLOW  = 4'b1000
    } region_t;

endpackage : bus_arb_pkg

// ---- src/sdram_port_arb.sv ----
// two-port sdram access arbiter: video dma port against system bus port
`timescale 1ns/1ps
`default_nettype none
module sdram_port_arb (
    input  wire logic                               ref_clk,
    input  wire logic                               rstn,
    input  wire logic                               sys_req,
    input  wire logic [bus_arb_pkg::ADDR_W-1:0]     sys_addr,
    input  wire logic                               vid_req,
    input  wire logic [bus_arb_pkg::ADDR_W-1:0]     vid_addr,
    output logic                                    sys_done,
    output logic                                    vid_done,
    output logic                                    beat_valid,
    output logic [bus_arb_pkg::ADDR_W-1:0]          beat_addr,
    output logic                                    beat_video
);
    bus_arb_pkg::sd_state_t            state_q, state_d;
    logic [bus_arb_pkg::BEAT_W-1:0]    beat_q,  beat_d;
    logic [1:0]                        vquad_q, vquad_d;
    logic [bus_arb_pkg::ADDR_W-1:0]    addr_q,  addr_d;
    logic                              last_beat;

    assign last_beat = (beat_q == bus_arb_pkg::BEAT_LAST);

    // burst sequencing; video wins at every burst start
    always_comb begin
        state_d  = state_q;
        beat_d   = beat_q;
        vquad_d  = vquad_q;
        addr_d   = addr_q;
        sys_done = 1'b0;
        vid_done = 1'b0;
        unique case (state_q)
            bus_arb_pkg::SD_IDLE: begin
                beat_d = '0;
                if (vid_req) begin
                    state_d = bus_arb_pkg::SD_VID;
                    vquad_d = '0;
                    addr_d  = vid_addr;
                end else if (sys_req) begin
                    state_d = bus_arb_pkg::SD_SYS;
                    addr_d  = sys_addr;
                end
            end
            bus_arb_pkg::SD_SYS: begin
                beat_d = beat_q + 3'h1;
                if (last_beat) begin
                    sys_done = 1'b1;
                    state_d  = bus_arb_pkg::SD_IDLE;
                end
            end
            bus_arb_pkg::SD_VID: begin
                beat_d = beat_q + 3'h1;
                if (last_beat) begin
                    addr_d  = addr_q + bus_arb_pkg::QUAD_BYTES;
                    vquad_d = vquad_q + 2'h1;
                    if (vquad_q == bus_arb_pkg::VID_QUAD_LAST) begin
                        vid_done = 1'b1;
                        state_d  = bus_arb_pkg::SD_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= bus_arb_pkg::SD_IDLE;
            beat_q  <= '0;
            vquad_q <= '0;
            addr_q  <= '0;
        end else begin
            state_q <= state_d;
            beat_q  <= beat_d;
            vquad_q <= vquad_d;
            addr_q  <= addr_d;
        end
    end

    // beat stream towards the memory pins
    assign beat_valid = (state_q != bus_arb_pkg::SD_IDLE);
    assign beat_video = (state_q == bus_arb_pkg::SD_VID);
    assign beat_addr  = addr_q;

endmodule : sdram_port_arb
`default_nettype wire

// ---- src/system_bus_arbitration.sv ----
// system bus arbiter, sdram port arbitration and peripheral bridge steering
`timescale 1ns/1ps
`default_nettype none
module system_bus_arbitration (
    input  wire logic                                   ref_clk,
    input  wire logic                                   rstn,
    input  wire logic                                   cpu_req,
    input  wire logic                                   dma_req,
    input  wire bus_arb_pkg::asb_xfer_t                 xfer,
    output logic                                        cpu_grant,
    output logic                                        dma_grant,
    output logic                                        bus_wait,
    output logic                                        bus_error,
    output logic                                        rom_sel,
    output logic                                        sdram_sel,
    input  wire logic                                   vid_req,
    input  wire logic [bus_arb_pkg::ADDR_W-1:0]         vid_addr,
    output logic                                        vid_done,
    output logic                                        sd_beat_valid,
    output logic [bus_arb_pkg::ADDR_W-1:0]              sd_beat_addr,
    output logic                                        sd_beat_video,
    input  wire bus_arb_pkg::dma_side_t                 dma_side,
    output logic                                        fast_sel,
    output logic                                        fast_write,
    output logic [bus_arb_pkg::DMA_CHANNELS-1:0]        fast_dma_sel,
    input  wire logic                                   xtal_clk,
    input  wire logic [bus_arb_pkg::DATA_W-1:0]         slow_rdata_in,
    output logic                                        slow_sel,
    output logic                                        slow_write,
    output logic                                        slow_xtal_tick,
    output logic [bus_arb_pkg::DATA_W-1:0]              slow_rdata
);
    // region decode, shared by select, wait and dma refusal logic
    function automatic bus_arb_pkg::region_t region_of(
        input logic [bus_arb_pkg::ADDR_W-1:0] a);
        logic [3:0] field;
        field = a[bus_arb_pkg::REGION_HI:bus_arb_pkg::REGION_LO];
        if (field == bus_arb_pkg::REGION_SDRAM)
            return bus_arb_pkg::RG_SDRAM;
        else if (field == bus_arb_pkg::REGION_FAST)
            return bus_arb_pkg::RG_FAST;
        else if (field == bus_arb_pkg::REGION_SLOW)
            return bus_arb_pkg::RG_SLOW;
        else
            return bus_arb_pkg::RG_ROM;
    endfunction : region_of

    bus_arb_pkg::region_t  region;
    bus_arb_pkg::owner_t   owner_q, owner_d;
    logic                  arb_point;
    logic                  quad_end;
    logic                  sd_busy_q, sd_busy_d;
    logic                  sys_sd_req;
    logic                  sys_done;
    logic                  dma_xfer;

    assign region   = region_of(xfer.addr);
    assign dma_xfer = xfer.active && (owner_q == bus_arb_pkg::OWN_DMA);

    // quad-word end: address bits 3 and 2 both set, transfer not stalled
    assign quad_end  = (xfer.addr[bus_arb_pkg::QUAD_HI:bus_arb_pkg::QUAD_LO]
                        == bus_arb_pkg::QUAD_LAST) && !bus_wait;
    // a line fill walks a whole quad, so it is never cut mid-line
    assign arb_point = !xfer.active || quad_end;

    // mastership: dma first, then cpu, else the owner stays
    always_comb begin
        owner_d = owner_q;
        if (arb_point) begin
            if (dma_req)
                owner_d = bus_arb_pkg::OWN_DMA;
            else if (cpu_req)
                owner_d = bus_arb_pkg::OWN_CPU;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            owner_q <= bus_arb_pkg::OWN_CPU;
        else
            owner_q <= owner_d;
    end

    assign cpu_grant = (owner_q == bus_arb_pkg::OWN_CPU);
    assign dma_grant = (owner_q == bus_arb_pkg::OWN_DMA);

    // system side of the sdram port: one burst per access, wait until done
    assign sys_sd_req = xfer.active && (region == bus_arb_pkg::RG_SDRAM)
                        && !sd_busy_q;

    // busy only from the edge at which the idle port really takes the system request;
    // a waiting video request wins that edge and the system request must stay up
    always_comb begin
        sd_busy_d = sd_busy_q;
        if (sys_done)
            sd_busy_d = 1'b0;
        else if (sys_sd_req && !sd_beat_valid && !vid_req)
            sd_busy_d = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            sd_busy_q <= 1'b0;
        else
            sd_busy_q <= sd_busy_d;
    end

    sdram_port_arb u_sdram_port (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .sys_req    (sys_sd_req),
        .sys_addr   (xfer.addr),
        .vid_req    (vid_req),
        .vid_addr   (vid_addr),
        .sys_done   (sys_done),
        .vid_done   (vid_done),
        .beat_valid (sd_beat_valid),
        .beat_addr  (sd_beat_addr),
        .beat_video (sd_beat_video)
    );

    // only sdram accesses may stall; rom and peripherals never see video
    assign bus_wait = xfer.active && (region == bus_arb_pkg::RG_SDRAM)
                      && !sys_done;

    // dma aimed at the slow bus is refused with an error answer
    assign bus_error = dma_xfer && (region == bus_arb_pkg::RG_SLOW);

    // slave selects and fast bridge steering, registered
    logic                                     rom_sel_d, sdram_sel_d;
    logic                                     fast_sel_d, fast_write_d;
    logic                                     slow_sel_d, slow_write_d;
    logic [bus_arb_pkg::DMA_CHANNELS-1:0]     fast_dma_sel_d;
    logic                                     rom_sel_q, sdram_sel_q;
    logic                                     fast_sel_q, fast_write_q;
    logic                                     slow_sel_q, slow_write_q;
    logic [bus_arb_pkg::DMA_CHANNELS-1:0]     fast_dma_sel_q;

    always_comb begin
        rom_sel_d      = xfer.active && (region == bus_arb_pkg::RG_ROM);
        sdram_sel_d    = xfer.active && (region == bus_arb_pkg::RG_SDRAM);
        slow_sel_d     = xfer.active && (region == bus_arb_pkg::RG_SLOW)
                         && !dma_xfer;
        slow_write_d   = xfer.write;
        fast_sel_d     = xfer.active && (region == bus_arb_pkg::RG_FAST)
                         && !dma_side.ack;
        fast_write_d   = xfer.write;
        fast_dma_sel_d = '0;
        if (dma_xfer && dma_side.ack) begin
            // fly-by: peripheral direction is the reverse of the bus one
            fast_write_d = !xfer.write;
            for (int i = 0; i < bus_arb_pkg::DMA_CHANNELS; i++) begin
                fast_dma_sel_d[i] = (dma_side.chan == i[bus_arb_pkg::CHAN_W-1:0]);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rom_sel_q      <= 1'b0;
            sdram_sel_q    <= 1'b0;
            fast_sel_q     <= 1'b0;
            fast_write_q   <= 1'b0;
            fast_dma_sel_q <= '0;
            slow_sel_q     <= 1'b0;
            slow_write_q   <= 1'b0;
        end else begin
            rom_sel_q      <= rom_sel_d;
            sdram_sel_q    <= sdram_sel_d;
            fast_sel_q     <= fast_sel_d;
            fast_write_q   <= fast_write_d;
            fast_dma_sel_q <= fast_dma_sel_d;
            slow_sel_q     <= slow_sel_d;
            slow_write_q   <= slow_write_d;
        end
    end

    assign rom_sel      = rom_sel_q;
    assign sdram_sel    = sdram_sel_q;
    assign fast_sel     = fast_sel_q;
    assign fast_write   = fast_write_q;
    assign fast_dma_sel = fast_dma_sel_q;
    assign slow_sel     = slow_sel_q;
    assign slow_write   = slow_write_q;

    // crystal clock and slow read data pass three flops each
    logic [bus_arb_pkg::SYNC_STAGES-1:0]  xtal_sync_q, xtal_sync_d;
    logic [bus_arb_pkg::DATA_W-1:0]       rd_s1_q, rd_s2_q, rd_s3_q;
    logic [bus_arb_pkg::DATA_W-1:0]       rd_s1_d, rd_s2_d, rd_s3_d;
    logic                                 xtal_lvl_q, xtal_lvl_d;
    logic                                 tick_q, tick_d;
    logic [bus_arb_pkg::DATA_W-1:0]       rdata_q, rdata_d;

    always_comb begin
        xtal_sync_d = {xtal_sync_q[bus_arb_pkg::SYNC_STAGES-2:0], xtal_clk};
        rd_s1_d     = slow_rdata_in;
        rd_s2_d     = rd_s1_q;
        rd_s3_d     = rd_s2_q;
        xtal_lvl_d  = xtal_lvl_q;
        tick_d      = 1'b0;
        rdata_d     = rdata_q;
        // a level counts once stages two and three agree
        if (xtal_sync_q[1] == xtal_sync_q[2]) begin
            xtal_lvl_d = xtal_sync_q[2];
            tick_d     = xtal_sync_q[2] && !xtal_lvl_q;
        end
        // a data word is taken only while it is stable across stages two and three
        if (rd_s2_q == rd_s3_q)
            rdata_d = rd_s3_q;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            xtal_sync_q <= '0;
            rd_s1_q     <= '0;
            rd_s2_q     <= '0;
            rd_s3_q     <= '0;
            xtal_lvl_q  <= 1'b0;
            tick_q      <= 1'b0;
            rdata_q     <= '0;
        end else begin
            xtal_sync_q <= xtal_sync_d;
            rd_s1_q     <= rd_s1_d;
            rd_s2_q     <= rd_s2_d;
            rd_s3_q     <= rd_s3_d;
            xtal_lvl_q  <= xtal_lvl_d;
            tick_q      <= tick_d;
            rdata_q     <= rdata_d;
        end
    end

    assign slow_xtal_tick = tick_q;
    assign slow_rdata     = rdata_q;

endmodule : system_bus_arbitration
`default_nettype wire

// ---- test/sys_arb_chk.sv ----
// assertions watching the ports of the arbitration block
`timescale 1ns/1ps
`default_nettype none
module sys_arb_chk (
    input wire logic                   ref_clk,
    input wire logic                   rstn,
    input wire logic                   cpu_req,
    input wire logic                   dma_req,
    input wire logic                   vid_req,
    input wire bus_arb_pkg::asb_xfer_t xfer,
    input wire bus_arb_pkg::dma_side_t dma_side,
    input wire logic                   cpu_grant,
    input wire logic                   dma_grant,
    input wire logic                   bus_wait,
    input wire logic                   bus_error,
    input wire logic                   sd_beat_valid,
    input wire logic                   sd_beat_video,
    input wire logic                   fast_write,
    input wire logic [3:0]             fast_dma_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // arbitration point and address region of the current transfer
    wire logic       arb_pt = !xfer.active || (xfer.addr[3:2] == 2'h3 && !bus_wait);
    wire logic [3:0] rg     = xfer.addr[31:28];

    a_grant_onehot: assert property (cpu_grant != dma_grant)
        else $error("grants not one-hot");
    a_grant_hold: assert property (!arb_pt |=> $stable(dma_grant))
        else $error("grant moved outside arbitration point");
    a_dma_first: assert property (arb_pt && dma_req |=> dma_grant)
        else $error("dma request not granted first");
    a_owner_pass: assert property (arb_pt && !dma_req && cpu_req |=> cpu_grant)
        else $error("processor not granted");
    a_eight_beats: assert property ($rose(sd_beat_valid) && !sd_beat_video |->
        sd_beat_valid[*8] ##1 !sd_beat_valid)
        else $error("system sdram burst not eight beats");
    a_video_first: assert property (vid_req && !sd_beat_valid && xfer.active &&
        rg == 4'h4 |=> sd_beat_video) else $error("video lost to system bus");
    a_rom_nowait: assert property (xfer.active && rg != 4'h4 |-> !bus_wait)
        else $error("non-sdram access stalled");
    a_slow_nodma: assert property (dma_grant && xfer.active && rg == 4'h9 |-> bus_error)
        else $error("dma to slow bus not refused");
    a_fly_steer: assert property (dma_grant && xfer.active && dma_side.ack |=>
        fast_dma_sel == 4'(4'h1 << $past(dma_side.chan)) && fast_write == !$past(xfer.write))
        else $error("fly-by steering wrong");

    c_dma_owner: cover property ($rose(dma_grant));
    c_video_end: cover property (sd_beat_video ##1 !sd_beat_video);
    c_fly_sel: cover property (|fast_dma_sel);
endmodule : sys_arb_chk
bind system_bus_arbitration sys_arb_chk u_chk (.ref_clk, .rstn, .cpu_req, .dma_req,
    .vid_req, .xfer, .dma_side, .cpu_grant, .dma_grant, .bus_wait, .bus_error,
    .sd_beat_valid, .sd_beat_video, .fast_write, .fast_dma_sel);
`default_nettype wire

// ---- test/vid_xtal_model.sv ----
// far side model: video requester and crystal domain source
`timescale 1ns/1ps
`default_nettype none
module vid_xtal_model #(
    parameter logic [31:0] VID_BASE = 32'h4000_0100
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        go,
    input  wire logic        sd_beat_video,
    input  wire logic        vid_done,
    output var  logic        vid_req,
    output var  logic [31:0] vid_addr,
    output var  logic        xtal_clk,
    output var  logic [31:0] slow_rdata_in
);
    // crystal at 3.6864 MHz, free running and unrelated in phase
    initial begin
        xtal_clk = 1'b0;
        slow_rdata_in = 32'h0000_0000;
        #7.3;
        forever #135.634 xtal_clk = ~xtal_clk;
    end
    // crystal domain data moves once per crystal period
    always @(posedge xtal_clk) slow_rdata_in <= slow_rdata_in + 32'h0101_0101;
    // one request per go, held to the end of the burst; only its start address counts
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vid_req  <= 1'b0;
            vid_addr <= VID_BASE;
        end else begin
            if (go)
                vid_req <= 1'b1;
            else if (vid_done)
                vid_req <= 1'b0;
            vid_addr <= (vid_req && sd_beat_video) ? ~VID_BASE : VID_BASE;
        end
    end
endmodule : vid_xtal_model
`default_nettype wire

// ---- test/system_bus_arbitration_test.sv ----
// self-checking bench for the system bus arbitration block
`timescale 1ns/1ps
`default_nettype none
module system_bus_arbitration_test;
    logic ref_clk, rstn, cpu_req, dma_req, go, cpu_grant, dma_grant, bus_wait, bus_error;
    logic rom_sel, sdram_sel, vid_req, vid_done, sd_beat_valid, sd_beat_video, fast_sel;
    logic fast_write, xtal_clk, slow_sel, slow_write, slow_xtal_tick;
    logic [31:0] vid_addr, sd_beat_addr, slow_rdata_in, slow_rdata;
    logic [3:0] fast_dma_sel;
    bus_arb_pkg::asb_xfer_t xfer;
    bus_arb_pkg::dma_side_t dma_side;
    int errors, cmp_count, cyc;

    system_bus_arbitration u_system_bus_arbitration (.ref_clk, .rstn, .cpu_req, .dma_req,
        .xfer, .cpu_grant, .dma_grant, .bus_wait, .bus_error, .rom_sel, .sdram_sel,
        .vid_req, .vid_addr, .vid_done, .sd_beat_valid, .sd_beat_addr, .sd_beat_video,
        .dma_side, .fast_sel, .fast_write, .fast_dma_sel, .xtal_clk, .slow_rdata_in,
        .slow_sel, .slow_write, .slow_xtal_tick, .slow_rdata);
    vid_xtal_model #(.VID_BASE(32'h4000_0100)) u_vid_xtal_model (.ref_clk, .rstn, .go,
        .sd_beat_video, .vid_done, .vid_req, .vid_addr, .xtal_clk, .slow_rdata_in);

    // 40 MHz clock and a cycle ceiling against hangs
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // present a transfer at a falling edge; step to the next and let it settle
    task automatic put(input logic a, input logic w, input logic [31:0] ad);
        @(negedge ref_clk);
        xfer <= '{active: a, write: w, addr: ad};
    endtask : put
    task automatic nxt;
        @(negedge ref_clk);
        #1;
    endtask : nxt

    // line fill with dma waiting: handover only after the last word
    task automatic t_arb;
        for (int i = 0; i < 4; i++) begin
            put(1'b1, 1'b0, 32'h0000_0020 + 32'(4 * i));
            cpu_req <= 1'b1;
            dma_req <= 1'b1;
            #1 chk(dma_grant, 0);
        end
        nxt();
        chk(dma_grant, 1);
        put(1'b1, 1'b0, 32'h0000_002c);
        dma_req <= 1'b0;
        nxt();
        chk(cpu_grant, 1);
        put(1'b0, 1'b0, 32'h0);
        cpu_req <= 1'b0;
        nxt();
        nxt();
        chk(cpu_grant, 1);
    endtask : t_arb
    // single sdram access costs one eight beat burst
    task automatic t_sdram;
        int n;
        n = 0;
        put(1'b1, 1'b0, 32'h4000_0040);
        #1;
        while (bus_wait === 1'b1 && n < 100) begin
            n++;
            nxt();
        end
        chk(n, 8);
        chk(sdram_sel, 1);
        put(1'b0, 1'b0, 32'h0);
        #1 chk(sd_beat_valid, 0);
    endtask : t_sdram
    // video burst beside a rom read, then video against a system sdram write
    task automatic t_video;
        int n;
        n = 0;
        @(negedge ref_clk);
        go <= 1'b1;
        put(1'b1, 1'b0, 32'h0000_0100);
        go <= 1'b0;
        #1;
        while (vid_done !== 1'b1 && n < 100) begin
            nxt();
            n += int'(sd_beat_video === 1'b1);
            if (n == 5) begin
                chk(bus_wait, 0);
                chk(rom_sel, 1);
            end
        end
        chk(n, 32);
        chk(sd_beat_addr, 32'h4000_0100 + 3 * bus_arb_pkg::QUAD_BYTES);
        n = 0;
        @(negedge ref_clk);
        go <= 1'b1;
        put(1'b1, 1'b1, 32'h4000_0200);
        go <= 1'b0;
        nxt();
        chk(sd_beat_video, 1);
        // whole video burst first, one idle cycle, then the eight system beats
        while (bus_wait === 1'b1 && n < 100) begin
            if (vid_done === 1'b1)
                chk(n, 31);
            n++;
            nxt();
        end
        chk(n, 40);
        put(1'b0, 1'b0, 32'h0);
    endtask : t_video
    // dma fly-by on every channel, then slow bus refused to dma, open to the cpu
    task automatic t_fly;
        put(1'b0, 1'b0, 32'h0);
        dma_req <= 1'b1;
        nxt();
        chk(dma_grant, 1);
        for (int c = 0; c < 4; c++) begin
            put(1'b1, 1'b1, 32'h8000_0000);
            dma_side <= '{ack: 1'b1, chan: 2'(c)};
            nxt();
            chk(fast_dma_sel, 32'h1 << c);
            chk(fast_write, 0);
            chk(fast_sel, 0);
        end
        put(1'b1, 1'b0, 32'h9000_0000);
        dma_side <= '0;
        #1 chk(bus_error, 1);
        nxt();
        chk(slow_sel, 0);
        put(1'b0, 1'b0, 32'h0);
        dma_req <= 1'b0;
        cpu_req <= 1'b1;
        put(1'b1, 1'b1, 32'h9000_0004);
        #1 chk(bus_error, 0);
        nxt();
        chk(slow_sel, 1);
        chk(slow_write, 1);
        put(1'b1, 1'b0, 32'h8000_0000);
        nxt();
        chk(fast_sel, 1);
        put(1'b0, 1'b0, 32'h0);
    endtask : t_fly
    // crystal ticks counted over 1085 cycles; data crosses intact
    task automatic t_xtal;
        int n;
        n = 0;
        for (int i = 0; i < 1085; i++) begin
            nxt();
            n += int'(slow_xtal_tick === 1'b1);
        end
        chk(n >= 99 && n <= 100, 1);
        for (int k = 0; k < 50 && slow_xtal_tick !== 1'b1; k++)
            nxt();
        repeat (3) nxt();
        chk(slow_rdata, slow_rdata_in);
    endtask : t_xtal

    // reset, then the scenarios in turn
    initial begin
        rstn = 1'b0;
        {cpu_req, dma_req, go} = 3'h0;
        xfer = '0;
        dma_side = '0;
        repeat (3) @(posedge ref_clk);
        chk(cpu_grant, 1);
        chk(dma_grant, 0);
        @(negedge ref_clk);
        rstn = 1'b1;
        t_arb();
        t_sdram();
        t_video();
        t_fly();
        t_xtal();
        report_and_stop();
    end
endmodule : system_bus_arbitration_test
`default_nettype wire
